// ---- core/io_port_pkg.sv ----
// Shared constants and types for the I/O port configuration logic
package io_port_pkg;

  // ==================================================================
  // Sizes
  // ==================================================================
  localparam int NUM_PORTS = 4;            // Ports A, B, C, D
  localparam int PIDX_W    = 2;            // Port index width
  localparam int REG_W     = 4;            // Register select width
  typedef logic [7:0] byte_t;              // One port-wide byte

  // ==================================================================
  // Address fields of the register port
  // ==================================================================
  localparam int PORT_FIELD_MSB = 7;       // Port select, top nibble
  localparam int PORT_FIELD_LSB = 4;
  localparam int REG_FIELD_MSB  = 3;       // Register select, low nibble
  localparam int REG_FIELD_LSB  = 0;
  localparam logic [3:0] PORT_LIMIT = 4'h4; // First unmapped port code

  // Register indices inside one port window
  localparam logic [REG_W-1:0] REG_DIN   = 4'h0; // pin_input_level
  localparam logic [REG_W-1:0] REG_DOUT  = 4'h1; // pin_output_value
  localparam logic [REG_W-1:0] REG_MODE  = 4'h2; // port_mode_select
  localparam logic [REG_W-1:0] REG_DIR   = 4'h3; // pin_direction
  localparam logic [REG_W-1:0] REG_DRIVE = 4'h4; // pin_drive_select
  localparam logic [REG_W-1:0] REG_IMC   = 4'h5; // input_cell_state
  localparam logic [REG_W-1:0] REG_OMC   = 4'h6; // output_cell_state
  localparam logic [REG_W-1:0] REG_MASK  = 4'h7; // cell_load_mask
  localparam logic [REG_W-1:0] REG_ENOUT = 4'h8; // driver_enable_view

  // memory_map_config register and its peripheral_mode_bit
  localparam logic [7:0] ADDR_MAP_CFG    = 8'h40;
  localparam int         PERIPH_BIT      = 7;
  localparam byte_t      MAP_MASK        = 8'h80;

  // ==================================================================
  // Reset values and per-port implemented bits
  // ==================================================================
  localparam byte_t CFG_RESET = 8'h00;
  localparam byte_t ZERO_BYTE = 8'h00;
  localparam byte_t ALL_ONES  = 8'hFF;
  localparam int    PORT_A_IDX = 0;
  localparam byte_t PIN_MASK  [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h06};
  localparam byte_t MODE_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'h00, 8'h00};
  localparam byte_t OD_MASK   [NUM_PORTS] = '{8'hF0, 8'hF0, 8'h9C, 8'h00};
  localparam byte_t SLEW_MASK [NUM_PORTS] = '{8'h0F, 8'h0F, 8'h00, 8'h06};
  localparam byte_t CELL_MASK [NUM_PORTS] = '{8'hFF, 8'hFF, 8'hFF, 8'h00};

endpackage : io_port_pkg

// ---- core/port_bus_if.sv ----
// Decoded register-port signals passed from the decoder to the core
`timescale 1ns/100ps
interface port_bus_if;
  import io_port_pkg::*;
  logic                 port_hit;  // Address lands in a port window
  logic [PIDX_W-1:0]    port_idx;  // Which port
  logic [REG_W-1:0]     reg_sel;   // Which register of the port
  logic [NUM_PORTS-1:0] wr_port;   // One-hot write strobe per port
  logic                 map_hit;   // Address is memory_map_config
  logic                 map_wr;    // Write to memory_map_config

  modport dec  (output port_hit, port_idx, reg_sel, wr_port, map_hit, map_wr);
  modport core (input  port_hit, port_idx, reg_sel, wr_port, map_hit, map_wr);
endinterface : port_bus_if

// ---- core/pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg;  // Chain stages
  logic [WIDTH-1:0] q_reg, q_next;           // Accepted level
  logic [WIDTH-1:0] differ;                  // Stages two and three disagree

  // ==================================================================
  // Acceptance: take stage three only where it agrees with stage two
  // ==================================================================
  always_comb begin
    differ = s2_reg ^ s3_reg;
    q_next = (~differ & s3_reg) | (differ & q_reg);
  end

  // Stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;

endmodule : pin_sync

// ---- core/bus_decode.sv ----
// Address decoder for the port register windows
`timescale 1ns/100ps
module bus_decode
  import io_port_pkg::*;
(
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic       wr,
  // Decoded view
  port_bus_if.dec         bus
);

  logic [3:0] port_field;  // Upper address nibble

  // ==================================================================
  // Window decode
  // ==================================================================
  assign port_field   = addr[PORT_FIELD_MSB:PORT_FIELD_LSB];
  assign bus.port_hit = port_field < PORT_LIMIT;
  assign bus.port_idx = port_field[PIDX_W-1:0];
  assign bus.reg_sel  = addr[REG_FIELD_MSB:REG_FIELD_LSB];
  assign bus.map_hit  = addr == ADDR_MAP_CFG;
  assign bus.map_wr   = wr & bus.map_hit;

  // One write strobe per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_wr
    assign bus.wr_port[p] = wr & bus.port_hit & (bus.port_idx == PIDX_W'(p));
  end

endmodule : bus_decode

// ---- core/io_port_config_logic.sv ----
// Port configuration, data and pin-driver logic for I/O ports A to D
`timescale 1ns/100ps
// ==================================================================
// Notes on behaviour
// - Mode bit 0 MCU I/O, 1 address out
// - Mode, direction, drive registers reset to zero
// - Register bit n configures pin n only
// - Direction 1 output, 0 input, default input
// - Driver enable is direction OR array term
// - Without array term, direction alone decides
// - Address mode drives latched address a7..a0
// - Port D direction keeps only bits 2, 1
// - Drive bit 1 makes pin open drain
// - Drive bit 1 selects fast slew
// - Drive bits split per port as listed
// - Data-in read returns sampled pin levels
// - Data-out stores byte, drives enabled pins
// - Cell read returns flops, output-cell write loads unmasked
// - Mask bit 1 blocks microcontroller cell load
// - Input cells feed array and read back
// - Enable-out read shows effective driver enables, ports A to C; port D reads zero
// - Peripheral bit makes port A data buffer
// - Peripheral buffer floats with both selects low
module io_port_config_logic
  import io_port_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Register port
  input  wire logic [7:0] BUS_ADDR,
  input  wire logic       BUS_WR,
  input  wire logic       BUS_RD,
  input  wire logic [7:0] BUS_WDATA,
  output logic      [7:0] BUS_RDATA,
  // Latched address and peripheral data path
  input  wire logic [7:0] LATCHED_ADDR,
  input  wire logic       PERIPH_SEL_A,
  input  wire logic       PERIPH_SEL_B,
  input  wire logic       PERIPH_WRITE,
  input  wire logic [7:0] PERIPH_WDATA,
  output logic      [7:0] PERIPH_RDATA,
  // Port A pins
  input  wire logic [7:0] PA_IN,
  output logic      [7:0] PA_OUT,
  output logic      [7:0] PA_OE_N,
  output logic      [7:0] PA_FAST_SLEW,
  // Port B pins
  input  wire logic [7:0] PB_IN,
  output logic      [7:0] PB_OUT,
  output logic      [7:0] PB_OE_N,
  output logic      [7:0] PB_FAST_SLEW,
  // Port C pins
  input  wire logic [7:0] PC_IN,
  output logic      [7:0] PC_OUT,
  output logic      [7:0] PC_OE_N,
  output logic      [7:0] PC_FAST_SLEW,
  // Port D pins
  input  wire logic [7:0] PD_IN,
  output logic      [7:0] PD_OUT,
  output logic      [7:0] PD_OE_N,
  output logic      [7:0] PD_FAST_SLEW,
  // Logic array terms, port A
  input  wire logic [7:0] PA_ARRAY_OE,
  input  wire logic [7:0] PA_ARRAY_SEL,
  input  wire logic [7:0] PA_IMC_LOAD,
  input  wire logic [7:0] PA_OMC_LOAD,
  input  wire logic [7:0] PA_OMC_D,
  output logic      [7:0] PA_IMC_Q,
  output logic      [7:0] PA_OMC_Q,
  // Logic array terms, port B
  input  wire logic [7:0] PB_ARRAY_OE,
  input  wire logic [7:0] PB_ARRAY_SEL,
  input  wire logic [7:0] PB_IMC_LOAD,
  input  wire logic [7:0] PB_OMC_LOAD,
  input  wire logic [7:0] PB_OMC_D,
  output logic      [7:0] PB_IMC_Q,
  output logic      [7:0] PB_OMC_Q,
  // Logic array terms, port C
  input  wire logic [7:0] PC_ARRAY_OE,
  input  wire logic [7:0] PC_ARRAY_SEL,
  input  wire logic [7:0] PC_IMC_LOAD,
  input  wire logic [7:0] PC_OMC_LOAD,
  input  wire logic [7:0] PC_OMC_D,
  output logic      [7:0] PC_IMC_Q,
  output logic      [7:0] PC_OMC_Q,
  // Logic array terms, port D
  input  wire logic [7:0] PD_ARRAY_OE
);

  // ==================================================================
  // Declarations
  // ==================================================================
  port_bus_if bus ();                       // Decoded register access

  byte_t mode_reg [NUM_PORTS];              // port_mode_select
  byte_t dir_reg  [NUM_PORTS];              // pin_direction
  byte_t drv_reg  [NUM_PORTS];              // pin_drive_select
  byte_t dout_reg [NUM_PORTS];              // pin_output_value
  byte_t omc_reg  [NUM_PORTS];              // output_cell_state
  byte_t mask_reg [NUM_PORTS];              // cell_load_mask
  byte_t imc_reg  [NUM_PORTS];              // input_cell_state
  byte_t map_reg, map_next;                 // memory_map_config
  byte_t rdata_reg, rdata_next;             // Read data holding register
  byte_t rd_val;                            // Selected read value

  byte_t pin_raw  [NUM_PORTS];              // Pin levels as they arrive
  byte_t pin_lvl  [NUM_PORTS];              // Synchronised pin levels
  byte_t arr_oe   [NUM_PORTS];              // Array enable terms
  byte_t arr_sel  [NUM_PORTS];              // Pin sourced from output cell
  byte_t imc_ld   [NUM_PORTS];              // Input cell capture terms
  byte_t omc_ld   [NUM_PORTS];              // Output cell load terms
  byte_t omc_d    [NUM_PORTS];              // Output cell array data
  byte_t pin_out  [NUM_PORTS];              // Pin output value
  byte_t pin_oe_n [NUM_PORTS];              // Pin driver enable, low drives
  byte_t en_view  [NUM_PORTS];              // Effective driver enables

  logic [8*NUM_PORTS-1:0] raw_flat, lvl_flat; // Synchroniser buses
  logic                   periph_on;          // Port A as data buffer
  logic                   psel_any;           // Either peripheral select

  // ==================================================================
  // Port gathering
  // ==================================================================
  assign pin_raw[0] = PA_IN;
  assign pin_raw[1] = PB_IN;
  assign pin_raw[2] = PC_IN;
  assign pin_raw[3] = PD_IN;
  assign arr_oe[0]  = PA_ARRAY_OE;
  assign arr_oe[1]  = PB_ARRAY_OE;
  assign arr_oe[2]  = PC_ARRAY_OE;
  assign arr_oe[3]  = PD_ARRAY_OE;
  assign arr_sel[0] = PA_ARRAY_SEL;
  assign arr_sel[1] = PB_ARRAY_SEL;
  assign arr_sel[2] = PC_ARRAY_SEL;
  assign arr_sel[3] = ZERO_BYTE;            // Port D has no output cells
  assign imc_ld[0]  = PA_IMC_LOAD;
  assign imc_ld[1]  = PB_IMC_LOAD;
  assign imc_ld[2]  = PC_IMC_LOAD;
  assign imc_ld[3]  = ZERO_BYTE;            // Port D has no input cells
  assign omc_ld[0]  = PA_OMC_LOAD;
  assign omc_ld[1]  = PB_OMC_LOAD;
  assign omc_ld[2]  = PC_OMC_LOAD;
  assign omc_ld[3]  = ZERO_BYTE;
  assign omc_d[0]   = PA_OMC_D;
  assign omc_d[1]   = PB_OMC_D;
  assign omc_d[2]   = PC_OMC_D;
  assign omc_d[3]   = ZERO_BYTE;

  // ==================================================================
  // Decoder and synchroniser
  // ==================================================================
  bus_decode u_decode (
    .addr (BUS_ADDR),
    .wr   (BUS_WR),
    .bus  (bus)
  );

  pin_sync #(.WIDTH(8*NUM_PORTS)) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .din   (raw_flat),
    .q     (lvl_flat)
  );

  // Peripheral mode controls
  assign periph_on = map_reg[PERIPH_BIT];
  assign psel_any  = PERIPH_SEL_A | PERIPH_SEL_B;

  // ==================================================================
  // Per-port registers and pin drivers
  // ==================================================================
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    byte_t mode_next, dir_next, drv_next, dout_next;  // Next config
    byte_t omc_next, mask_next, imc_next;             // Next cell state
    byte_t en_cfg, src, val, en_eff, od;              // Driver terms

    assign raw_flat[8*p +: 8] = pin_raw[p];
    assign pin_lvl[p]         = lvl_flat[8*p +: 8];

    // Register next values; bits a port lacks stay zero
    always_comb begin
      mode_next = mode_reg[p];
      dir_next  = dir_reg[p];
      drv_next  = drv_reg[p];
      dout_next = dout_reg[p];
      mask_next = mask_reg[p];
      imc_next  = ((imc_reg[p] & ~imc_ld[p]) | (pin_lvl[p] & imc_ld[p])) & CELL_MASK[p];
      // Array loads the output cells first
      omc_next  = (omc_reg[p] & ~omc_ld[p]) | (omc_d[p] & omc_ld[p]);
      if (bus.wr_port[p]) begin
        case (bus.reg_sel)
          REG_MODE:  mode_next = BUS_WDATA & MODE_MASK[p];
          REG_DIR:   dir_next  = BUS_WDATA & PIN_MASK[p];
          REG_DRIVE: drv_next  = BUS_WDATA & (OD_MASK[p] | SLEW_MASK[p]);
          REG_DOUT:  dout_next = BUS_WDATA & PIN_MASK[p];
          REG_MASK:  mask_next = BUS_WDATA & CELL_MASK[p];
          REG_OMC:   omc_next  = (omc_next & mask_reg[p]) | (BUS_WDATA & ~mask_reg[p]);
          default:   ;                     // Read-only or unused index
        endcase
      end
      omc_next = omc_next & CELL_MASK[p];
    end

    always_ff @(posedge CLK) begin
      if (!RSTN) begin
        mode_reg[p] <= CFG_RESET;
        dir_reg[p]  <= CFG_RESET;
        drv_reg[p]  <= CFG_RESET;
        dout_reg[p] <= CFG_RESET;
        omc_reg[p]  <= CFG_RESET;
        mask_reg[p] <= CFG_RESET;
        imc_reg[p]  <= CFG_RESET;
      end else begin
        mode_reg[p] <= mode_next;
        dir_reg[p]  <= dir_next;
        drv_reg[p]  <= drv_next;
        dout_reg[p] <= dout_next;
        omc_reg[p]  <= omc_next;
        mask_reg[p] <= mask_next;
        imc_reg[p]  <= imc_next;
      end
    end

    // enable is direction OR array term, per bit
    assign en_cfg = (dir_reg[p] | arr_oe[p]) & PIN_MASK[p];

    // source: address, output cell, or data out
    assign src = (mode_reg[p] & LATCHED_ADDR)
               | (~mode_reg[p] & arr_sel[p] & omc_reg[p])
               | (~mode_reg[p] & ~arr_sel[p] & dout_reg[p]);

    if (p == PORT_A_IDX) begin : g_periph
      // port A buffer driven only on selected writes
      assign en_eff = periph_on ? ({8{psel_any & PERIPH_WRITE}} & PIN_MASK[p]) : en_cfg;
      assign val    = periph_on ? PERIPH_WDATA : (src & PIN_MASK[p]);
    end else begin : g_plain
      assign en_eff = en_cfg;
      assign val    = src & PIN_MASK[p];
    end

    // open-drain pins release instead of driving high
    assign od          = drv_reg[p] & OD_MASK[p];
    assign pin_out[p]  = val;
    assign pin_oe_n[p] = ~(en_eff & ~(od & val));
    assign en_view[p]  = en_eff;
  end

  // ==================================================================
  // Read mux and read data register
  // ==================================================================
  always_comb begin
    rd_val = ZERO_BYTE;
    if (bus.map_hit) begin
      rd_val = map_reg;
    end else if (bus.port_hit) begin
      case (bus.reg_sel)
        REG_DIN:   rd_val = pin_lvl[bus.port_idx] & PIN_MASK[bus.port_idx];
        REG_DOUT:  rd_val = dout_reg[bus.port_idx];
        REG_MODE:  rd_val = mode_reg[bus.port_idx];
        REG_DIR:   rd_val = dir_reg[bus.port_idx];
        REG_DRIVE: rd_val = drv_reg[bus.port_idx];
        REG_IMC:   rd_val = imc_reg[bus.port_idx];
        REG_OMC:   rd_val = omc_reg[bus.port_idx];
        REG_MASK:  rd_val = mask_reg[bus.port_idx];
        // effective enables, only where cells exist
        REG_ENOUT: rd_val = en_view[bus.port_idx] & CELL_MASK[bus.port_idx];
        default:   rd_val = ZERO_BYTE;     // Unmapped index reads zero
      endcase
    end
  end

  // Read data and memory_map_config next values
  always_comb begin
    rdata_next = BUS_RD ? rd_val : rdata_reg;
    map_next   = bus.map_wr ? (BUS_WDATA & MAP_MASK) : map_reg;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rdata_reg <= ZERO_BYTE;
      map_reg   <= CFG_RESET;
    end else begin
      rdata_reg <= rdata_next;
      map_reg   <= map_next;
    end
  end

  // ==================================================================
  // Outputs
  // ==================================================================
  assign BUS_RDATA    = rdata_reg;
  assign PERIPH_RDATA = pin_lvl[PORT_A_IDX];
  assign PA_OUT       = pin_out[0];
  assign PB_OUT       = pin_out[1];
  assign PC_OUT       = pin_out[2];
  assign PD_OUT       = pin_out[3];
  assign PA_OE_N      = pin_oe_n[0];
  assign PB_OE_N      = pin_oe_n[1];
  assign PC_OE_N      = pin_oe_n[2];
  assign PD_OE_N      = pin_oe_n[3];
  // fast slew only on slew-capable bits
  assign PA_FAST_SLEW = drv_reg[0] & SLEW_MASK[0];
  assign PB_FAST_SLEW = drv_reg[1] & SLEW_MASK[1];
  assign PC_FAST_SLEW = drv_reg[2] & SLEW_MASK[2];
  assign PD_FAST_SLEW = drv_reg[3] & SLEW_MASK[3];
  assign PA_IMC_Q     = imc_reg[0];
  assign PB_IMC_Q     = imc_reg[1];
  assign PC_IMC_Q     = imc_reg[2];
  assign PA_OMC_Q     = omc_reg[0];
  assign PB_OMC_Q     = omc_reg[1];
  assign PC_OMC_Q     = omc_reg[2];

endmodule : io_port_config_logic

// ---- testbench/port_checks_assertions.sv ----
// Concurrent checks on the ports of the port configuration logic
`timescale 1ns/100ps
module port_checks (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // Register port
  input wire logic [7:0] BUS_ADDR,
  input wire logic       BUS_WR,
  input wire logic       BUS_RD,
  input wire logic [7:0] BUS_WDATA,
  input wire logic [7:0] BUS_RDATA,
  // Pin side
  input wire logic [7:0] PA_FAST_SLEW,
  input wire logic [7:0] PB_FAST_SLEW,
  input wire logic [7:0] PB_ARRAY_OE,
  input wire logic [7:0] PB_OE_N,
  input wire logic [7:0] PC_ARRAY_OE,
  input wire logic [7:0] PC_OUT,
  input wire logic [7:0] PC_OE_N,
  // Port A output cells
  input wire logic [7:0] PA_OMC_LOAD,
  input wire logic [7:0] PA_OMC_Q
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [7:0] mask_reg;  // Copy of the port A load mask
  // ==================================================================
  // Helper: follows CPU writes to the port A load mask
  // ==================================================================
  always_ff @(posedge CLK) begin
    if (!RSTN)
      mask_reg <= 8'h00;
    else if (BUS_WR && BUS_ADDR == 8'h07)
      mask_reg <= BUS_WDATA;
  end
  // ==================================================================
  // Assertions
  // ==================================================================
  a_read_holds: assert property (!BUS_RD |=> $stable(BUS_RDATA))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (BUS_RD && BUS_ADDR[7:4] > 4'h3 && BUS_ADDR != 8'h40
    |=> BUS_RDATA == 8'h00) else $error("unmapped read not zero");
  a_dir_readback: assert property (BUS_WR && BUS_ADDR == 8'h03 ##2 BUS_RD && !BUS_WR
    && BUS_ADDR == 8'h03 |=> BUS_RDATA == $past(BUS_WDATA, 3))
    else $error("direction readback wrong");
  a_portd_dir: assert property (BUS_RD && BUS_ADDR == 8'h33
    |=> (BUS_RDATA & 8'hF9) == 8'h00) else $error("port D direction extra bits");
  a_drive_c_bits: assert property (BUS_RD && BUS_ADDR == 8'h24
    |=> (BUS_RDATA & 8'h63) == 8'h00) else $error("port C drive extra bits");
  a_slew_follows: assert property (BUS_WR && BUS_ADDR == 8'h04
    |=> PA_FAST_SLEW == ($past(BUS_WDATA) & 8'h0F)) else $error("port A slew wrong");
  a_mask_blocks: assert property (BUS_WR && BUS_ADDR == 8'h06 && PA_OMC_LOAD == 8'h00
    |=> PA_OMC_Q == (($past(BUS_WDATA) & ~$past(mask_reg)) | ($past(PA_OMC_Q)
    & $past(mask_reg)))) else $error("masked cell load wrong");
  a_array_oe: assert property (PC_ARRAY_OE[7] && !PC_OUT[7] |-> !PC_OE_N[7])
    else $error("array enable did not drive");
  a_reset_clear: assert property ($rose(RSTN) |-> PB_FAST_SLEW == 8'h00
    && (PB_ARRAY_OE != 8'h00 || PB_OE_N == 8'hFF)) else $error("not clear after reset");
  // Main scenarios seen
  c_cell_write: cover property (BUS_WR && BUS_ADDR == 8'h06);
  c_map_read: cover property (BUS_RD && BUS_ADDR == 8'h40);
  c_array_drive: cover property (PC_ARRAY_OE[7] && !PC_OE_N[7]);
endmodule : port_checks

// ---- testbench/pin_board.sv ----
// Board model: resolves each pin from the design driver or the outside level
`timescale 1ns/100ps
module pin_board (
  // Design drivers, ports D..A packed
  input  wire logic [31:0] out,
  input  wire logic [31:0] oe_n,
  // Outside level: pull-up or another part
  input  wire logic [31:0] ext,
  // Resolved pin levels
  output logic      [31:0] pins
);
  // ==================================================================
  // Pin resolution
  // ==================================================================
  // outside level seen when released
  assign pins = (out & ~oe_n) | (ext & oe_n);
endmodule : pin_board

// ---- testbench/tb_top.sv ----
// Self-checking bench for the port configuration logic
`timescale 1ns/100ps
module tb_top;
  import io_port_pkg::*;
  // ==================================================================
  // Stimulus and observed signals
  // ==================================================================
  logic CLK = 0, RSTN = 0, BUS_WR = 0, BUS_RD = 0;
  logic PERIPH_SEL_A = 0, PERIPH_SEL_B = 0, PERIPH_WRITE = 0;
  logic [7:0] BUS_ADDR = 8'h00, BUS_WDATA = 8'h00, PERIPH_WDATA = 8'h00;
  logic [7:0] LATCHED_ADDR = 8'hA5;                  // Latched address
  logic [7:0] aoe = 8'h00, asel = 8'h00, ild = 8'h00; // Shared array terms
  logic [7:0] old = 8'h00, od = 8'h00;
  logic [31:0] ext = 32'h0F3C_C3A5;                  // Board levels
  wire [7:0] PA_ARRAY_OE = aoe, PB_ARRAY_OE = aoe, PC_ARRAY_OE = aoe, PD_ARRAY_OE = aoe;
  wire [7:0] PA_ARRAY_SEL = asel, PB_ARRAY_SEL = asel, PC_ARRAY_SEL = asel;
  wire [7:0] PA_IMC_LOAD = ild, PB_IMC_LOAD = ild, PC_IMC_LOAD = ild;
  wire [7:0] PA_OMC_LOAD = old, PB_OMC_LOAD = old, PC_OMC_LOAD = old;
  wire [7:0] PA_OMC_D = od, PB_OMC_D = od, PC_OMC_D = od;
  wire [7:0] BUS_RDATA, PERIPH_RDATA, PA_IN, PB_IN, PC_IN, PD_IN;
  wire [7:0] PA_OUT, PB_OUT, PC_OUT, PD_OUT, PA_OE_N, PB_OE_N, PC_OE_N, PD_OE_N;
  wire [7:0] PA_FAST_SLEW, PB_FAST_SLEW, PC_FAST_SLEW, PD_FAST_SLEW;
  wire [7:0] PA_IMC_Q, PB_IMC_Q, PC_IMC_Q, PA_OMC_Q, PB_OMC_Q, PC_OMC_Q;
  int fails = 0, check_count = 0, cyc = 0;
  io_port_config_logic dut (.*);
  pin_board board (.out({PD_OUT, PC_OUT, PB_OUT, PA_OUT}),
                   .oe_n({PD_OE_N, PC_OE_N, PB_OE_N, PA_OE_N}),
                   .ext(ext), .pins({PD_IN, PC_IN, PB_IN, PA_IN}));
  // Clock and hang guard
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out();
    end
  end
  // ==================================================================
  // Shared tasks
  // ==================================================================
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    BUS_ADDR <= a;
    BUS_WDATA <= d;
    BUS_WR <= 1'b1;
    @(posedge CLK);
    BUS_WR <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    BUS_ADDR <= a;
    BUS_RD <= 1'b1;
    @(posedge CLK);
    BUS_RD <= 1'b0;
    #1 chk(BUS_RDATA, exp);
  endtask : rd
  // ==================================================================
  // Scenarios
  // ==================================================================
  // config cleared
  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      for (int r = 2; r < 5; r++) begin
        rd({p[3:0], r[3:0]}, 8'h00);
      end
    end
    chk(PA_OE_N, 8'hFF);
    $display("reset test done");
  endtask : t_reset
  task automatic t_inputs;
    rd(8'h20, 8'h3C);
    rd(8'h30, 8'h06);
    rd(8'h50, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    @(posedge CLK);
    ild <= 8'hFF;
    repeat (2) @(posedge CLK);
    rd(8'h05, 8'hA5);
    chk(PA_IMC_Q, 8'hA5);
    chk(PB_IMC_Q, 8'hC3);
    chk(PC_IMC_Q, 8'h3C);
    // array inputs released before pins are driven
    @(posedge CLK);
    ild <= 8'h00;
    $display("input test done");
  endtask : t_inputs
  task automatic t_cells;
    wr(8'h07, 8'h0F);
    rd(8'h07, 8'h0F);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'hF0);
    chk(PA_OMC_Q, 8'hF0);
    chk(PB_OMC_Q, 8'h00);
    // Array loads port C cells, pins take the cell value
    @(posedge CLK);
    asel <= 8'hFF;
    old  <= 8'hFF;
    od   <= 8'h5A;
    @(posedge CLK);
    old  <= 8'h00;
    #1 chk(PC_OMC_Q, 8'h5A);
    chk(PC_OUT, 8'h5A);
    @(posedge CLK);
    asel <= 8'h00;
    $display("cell test done");
  endtask : t_cells
  task automatic t_dir;
    wr(8'h03, 8'h07);
    rd(8'h03, 8'h07);
    chk(PA_OE_N, 8'hF8);
    rd(8'h08, 8'h07);
    @(posedge CLK);
    aoe <= 8'h80;
    #1 chk(PA_OE_N, 8'h78);
    rd(8'h28, 8'h80);
    @(posedge CLK);
    aoe <= 8'h00;
    #1 chk(PA_OE_N, 8'hF8);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h06);
    chk(PD_OE_N, 8'hF9);
    wr(8'h31, 8'hFF);
    chk(PD_OUT, 8'h06);
    $display("direction test done");
  endtask : t_dir
  task automatic t_drive;
    byte_t dmask [4] = '{8'hFF, 8'hFF, 8'h9C, 8'h06};
    for (int p = 0; p < 4; p++) begin
      wr({p[3:0], 4'h4}, 8'hFF);
      rd({p[3:0], 4'h4}, dmask[p]);
    end
    chk(PA_FAST_SLEW, 8'h0F);
    chk(PC_FAST_SLEW, 8'h00);
    chk(PD_FAST_SLEW, 8'h06);
    wr(8'h03, 8'hFF);
    wr(8'h01, 8'hF0);
    chk(PA_OE_N, 8'hF0);
    repeat (4) @(posedge CLK);
    rd(8'h00, 8'hA0);
    wr(8'h04, 8'h00);
    chk(PA_OE_N, 8'h00);
    wr(8'h03, 8'h00);
    $display("drive test done");
  endtask : t_drive
  task automatic t_addr;
    wr(8'h13, 8'hFF);
    wr(8'h11, 8'h3C);
    chk(PB_OUT, 8'h3C);
    rd(8'h11, 8'h3C);
    wr(8'h12, 8'h0F);
    chk(PB_OUT, 8'h35);
    wr(8'h12, 8'hF0);
    chk(PB_OUT, 8'hAC);
    $display("address test done");
  endtask : t_addr
  task automatic t_periph;
    wr(8'h40, 8'h80);
    rd(8'h40, 8'h80);
    @(posedge CLK);
    PERIPH_SEL_A <= 1'b1;
    PERIPH_WRITE <= 1'b1;
    PERIPH_WDATA <= 8'h3C;
    #1 chk(PA_OUT, 8'h3C);
    chk(PA_OE_N, 8'h00);
    @(posedge CLK);
    PERIPH_SEL_A <= 1'b0;
    PERIPH_SEL_B <= 1'b1;
    #1 chk(PA_OE_N, 8'h00);
    @(posedge CLK);
    PERIPH_SEL_B <= 1'b0;
    #1 chk(PA_OE_N, 8'hFF);
    repeat (4) @(posedge CLK);
    #1 chk(PERIPH_RDATA, 8'hA5);
    $display("peripheral test done");
  endtask : t_periph
  // Main sequence
  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    t_reset();
    t_inputs();
    t_cells();
    t_dir();
    t_drive();
    t_addr();
    t_periph();
    close_out();
  end
endmodule : tb_top
bind io_port_config_logic port_checks checks (.*);
